// ### restart_prevention_pkg.sv
// Summary of operation
// - Completion indication only after the configured delay since the request.
// - Activity output held from request until the function is acknowledged.
// - Completion held until request withdrawn and acknowledged, or until a new request comes before the acknowledge, then dropped.
// - Completion output means motor stopped and torque removal in effect.
// - Request read from two separate digital input channels.
// - Enabled input test pulse checks; missing pulses are a wiring fault.
// - Enabled output test pulse check verifies pulses on the indication output.
// - Active-high polarity drives the output on while its signal is active.
// - Activation raises request warning and premature fault; never maskable.
// - Automatic mode acknowledges internally once the request is removed.
// - Manual mode accepts the button only after the request is removed.
package restart_prevention_pkg;

  localparam int unsigned CLK_HZ = 25_000_000;

  // Longest gap between test pulses before a channel is declared dead
  localparam int unsigned PULSE_GAP_MS     = 50;
  localparam int unsigned PULSE_GAP_CYCLES = (CLK_HZ / 1000) * PULSE_GAP_MS;
  // Channel disagreement tolerated before a discrepancy is flagged
  localparam int unsigned DISC_MS          = 100;
  localparam int unsigned DISC_CYCLES      = (CLK_HZ / 1000) * DISC_MS;
  // Default completion delay
  localparam int unsigned DELAY_MS_DEFAULT = 1000;
  localparam int unsigned DELAY_CYCLES_DEF = (CLK_HZ / 1000) * DELAY_MS_DEFAULT;
  // Test pulse width driven on the indication output
  localparam int unsigned OUT_PULSE_CYCLES = 25;

  localparam int unsigned CNT_W = 32;
  localparam int unsigned ADDR_W = 4;

  // Register offsets (word index, byte address is four times this)
  localparam logic [ADDR_W-1:0] CTRL_OFS   = 4'h0;
  localparam logic [ADDR_W-1:0] DELAY_OFS  = 4'h1;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h2;
  localparam logic [ADDR_W-1:0] EVENT_OFS  = 4'h3;
  localparam logic [ADDR_W-1:0] MASK_OFS   = 4'h4;

  // Control field positions
  localparam int unsigned CTRL_ENABLE    = 0;
  localparam int unsigned CTRL_ACK_MAN   = 1;
  localparam int unsigned CTRL_PULSE_A   = 2;
  localparam int unsigned CTRL_PULSE_B   = 3;
  localparam int unsigned CTRL_PULSE_OUT = 4;
  localparam int unsigned CTRL_POL_HIGH  = 5;
  localparam int unsigned CTRL_W         = 6;
  // Enabled, automatic, all pulses on, active high
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h3D;

  // Event bit positions
  localparam int unsigned EV_REQ_WARN   = 0;
  localparam int unsigned EV_PREMATURE  = 1;
  localparam int unsigned EV_WIRE_A     = 2;
  localparam int unsigned EV_WIRE_B     = 3;
  localparam int unsigned EV_WIRE_OUT   = 4;
  localparam int unsigned EV_DISC       = 5;
  localparam int unsigned EV_W          = 6;
  // Events that configuration may never hide
  localparam logic [EV_W-1:0] EV_FORCED = 6'h03;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DELAY,
    ST_DONE,
    ST_WAIT_ACK
  } seq_state_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } reg_req_t;

  typedef struct packed {
    logic ch_a;
    logic ch_b;
    logic ack_button;
    logic out_readback;
  } safe_in_t;

  typedef struct packed {
    logic activity;
    logic completion;
  } safe_out_t;

endpackage

// ### pulse_watchdog.sv
`timescale 1ns/1ps
// Flags a channel whose test pulses stop arriving
module pulse_watchdog
  import restart_prevention_pkg::*;
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic enable,
  input  wire logic pulse_seen,
  output logic      missing
);

  logic [CNT_W-1:0] gap_reg;

  // Gap counter restarts on every pulse; disabled check stays quiet
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gap_reg <= '0;
    end else if (!enable || pulse_seen) begin
      gap_reg <= '0;
    end else if (gap_reg < CNT_W'(PULSE_GAP_CYCLES)) begin
      gap_reg <= gap_reg + 1'b1;
    end
  end

  // Registered so the flag never glitches
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      missing <= 1'b0;
    end else begin
      missing <= enable && (gap_reg >= CNT_W'(PULSE_GAP_CYCLES));
    end
  end

endmodule

// ### start_prevention_indicator.sv
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
module start_prevention_indicator
  import restart_prevention_pkg::*;
(
  input  wire logic                                 clk,
  input  wire logic                                 rstn,
  input  wire restart_prevention_pkg::reg_req_t     bus_req,
  output logic      [31:0]                          rdata,
  input  wire restart_prevention_pkg::safe_in_t     pins_in,
  output restart_prevention_pkg::safe_out_t         pins_out,
  output logic                                      irq
);
  import restart_prevention_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  safe_in_t meta_reg;
  safe_in_t sync_reg;
  safe_in_t prev_reg;

  // Two stages before any logic reads a pin; prev feeds edge detection only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= pins_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [CTRL_W-1:0] ctrl_reg;
  logic [CNT_W-1:0]  delay_reg;
  logic [EV_W-1:0]   event_reg;
  logic [EV_W-1:0]   mask_reg;
  logic [EV_W-1:0]   event_set;

  function automatic logic hit(input reg_req_t r, input logic [ADDR_W-1:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  // Software configuration
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg  <= CTRL_RESET;
      delay_reg <= CNT_W'(DELAY_CYCLES_DEF);
    end else begin
      if (hit(bus_req, CTRL_OFS)) begin
        ctrl_reg <= bus_req.wdata[CTRL_W-1:0];
      end
      if (hit(bus_req, DELAY_OFS)) begin
        delay_reg <= bus_req.wdata[CNT_W-1:0];
      end
    end
  end

  // Forced events ignore the mask so they cannot be hidden
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mask_reg <= EV_FORCED;
    end else if (hit(bus_req, MASK_OFS)) begin
      mask_reg <= bus_req.wdata[EV_W-1:0] | EV_FORCED;
    end
  end

  // Sticky events: write one to clear, a new event wins over the clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      event_reg <= '0;
    end else if (hit(bus_req, EVENT_OFS)) begin
      event_reg <= (event_reg & ~bus_req.wdata[EV_W-1:0]) | event_set;
    end else begin
      event_reg <= event_reg | event_set;
    end
  end

  assign irq = |(event_reg & (mask_reg | EV_FORCED));

  ////////////////////////////////////////////////////////////////////////////////
  // Dual channel request

  logic             req_both;
  logic             disagree;
  logic [CNT_W-1:0] disc_reg;
  logic             disc_flag_reg;

  // Open switch pulls both channels; either alone is not a request
  assign req_both = sync_reg.ch_a && sync_reg.ch_b;
  assign disagree = sync_reg.ch_a ^ sync_reg.ch_b;

  // Short skew between contacts is normal, only persistent mismatch counts
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      disc_reg      <= '0;
      disc_flag_reg <= 1'b0;
    end else begin
      if (!disagree) begin
        disc_reg <= '0;
      end else if (disc_reg < CNT_W'(DISC_CYCLES)) begin
        disc_reg <= disc_reg + 1'b1;
      end
      disc_flag_reg <= disagree && (disc_reg >= CNT_W'(DISC_CYCLES));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Test pulse monitors

  logic miss_a;
  logic miss_b;
  logic miss_out;
  logic miss_a_prev_reg;
  logic miss_b_prev_reg;
  logic miss_out_prev_reg;
  logic disc_prev_reg;

  // Test pulses show as a dip on a held-high input
  pulse_watchdog wd_a (
    .clk        (clk),
    .rstn       (rstn),
    .enable     (ctrl_reg[CTRL_PULSE_A] && sync_reg.ch_a),
    .pulse_seen (prev_reg.ch_a && !sync_reg.ch_a),
    .missing    (miss_a)
  );

  pulse_watchdog wd_b (
    .clk        (clk),
    .rstn       (rstn),
    .enable     (ctrl_reg[CTRL_PULSE_B] && sync_reg.ch_b),
    .pulse_seen (prev_reg.ch_b && !sync_reg.ch_b),
    .missing    (miss_b)
  );

  logic [7:0] opulse_reg;
  logic       out_level;
  logic       out_test;

  // The output readback must follow our own test pulses
  pulse_watchdog wd_out (
    .clk        (clk),
    .rstn       (rstn),
    .enable     (ctrl_reg[CTRL_PULSE_OUT] && out_level),
    .pulse_seen (prev_reg.out_readback && !sync_reg.out_readback),
    .missing    (miss_out)
  );

  // Periodic short dip on the output while it is high
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      opulse_reg <= '0;
    end else begin
      opulse_reg <= opulse_reg + 1'b1;
    end
  end

  assign out_test = ctrl_reg[CTRL_PULSE_OUT] && (opulse_reg < 8'(OUT_PULSE_CYCLES));

  // Edge-detect the fault flags into events
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      miss_a_prev_reg   <= 1'b0;
      miss_b_prev_reg   <= 1'b0;
      miss_out_prev_reg <= 1'b0;
      disc_prev_reg     <= 1'b0;
    end else begin
      miss_a_prev_reg   <= miss_a;
      miss_b_prev_reg   <= miss_b;
      miss_out_prev_reg <= miss_out;
      disc_prev_reg     <= disc_flag_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Restart prevention sequence

  seq_state_t       state_reg;
  seq_state_t       state_next;
  logic [CNT_W-1:0] count_reg;
  logic             ack;
  logic             ack_btn_rise;
  logic             activate;

  assign ack_btn_rise = sync_reg.ack_button && !prev_reg.ack_button;
  // Automatic mode acks on removal; manual waits for a fresh button press
  assign ack = ctrl_reg[CTRL_ACK_MAN] ? (ack_btn_rise && !req_both) : !req_both;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (ctrl_reg[CTRL_ENABLE] && req_both) begin
          state_next = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (!req_both) begin
          state_next = ST_WAIT_ACK;
        end else if (count_reg >= delay_reg) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!req_both) begin
          state_next = ST_WAIT_ACK;
        end
      end
      ST_WAIT_ACK: begin
        if (req_both) begin
          state_next = ST_DELAY;
        end else if (ack) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Delay count starts from zero for every request and clears on withdrawal
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= '0;
    end else if (state_reg != ST_DELAY || state_next != ST_DELAY) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + 1'b1;
    end
  end

  assign activate = (state_reg == ST_IDLE) && (state_next == ST_DELAY);

  // Completion stays set through the wait for ack, since torque is still off
  logic done_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      done_reg <= 1'b0;
    end else if (state_next == ST_DONE) begin
      done_reg <= 1'b1;
    end else if (state_next == ST_IDLE || state_next == ST_DELAY) begin
      done_reg <= 1'b0;
    end
  end

  always_comb begin
    event_set               = '0;
    event_set[EV_REQ_WARN]  = activate;
    event_set[EV_PREMATURE] = activate;
    event_set[EV_WIRE_A]    = miss_a && !miss_a_prev_reg;
    event_set[EV_WIRE_B]    = miss_b && !miss_b_prev_reg;
    event_set[EV_WIRE_OUT]  = miss_out && !miss_out_prev_reg;
    event_set[EV_DISC]      = disc_flag_reg && !disc_prev_reg;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs and read path

  // Polarity inverts the indication; test dips apply whenever the level is high, under either polarity
  assign out_level = ctrl_reg[CTRL_POL_HIGH] ? done_reg : !done_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pins_out <= '0;
    end else begin
      pins_out.activity   <= state_next != ST_IDLE;
      pins_out.completion <= out_level && !out_test;
    end
  end

  // Unmapped offsets read zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= '0;
    end else begin
      rdata <= '0;
      if (bus_req.rd) begin
        unique case (bus_req.addr)
          CTRL_OFS:   rdata <= 32'(ctrl_reg);
          DELAY_OFS:  rdata <= delay_reg;
          STATUS_OFS: rdata <= {26'h0, disc_flag_reg, miss_out, miss_b, miss_a,
                                done_reg, state_reg != ST_IDLE};
          EVENT_OFS:  rdata <= 32'(event_reg);
          MASK_OFS:   rdata <= 32'(mask_reg);
          default:    rdata <= '0;
        endcase
      end
    end
  end

endmodule

// ### start_prevention_checker.sv
`timescale 1ns/1ps
module start_prevention_checker
  import restart_prevention_pkg::*;
(
  input wire logic                              clk,
  input wire logic                              rstn,
  input wire restart_prevention_pkg::reg_req_t  bus_req,
  input wire logic [31:0]                       rdata,
  input wire restart_prevention_pkg::safe_in_t  pins_in,
  input wire restart_prevention_pkg::safe_out_t pins_out,
  input wire logic                              irq
);
  import restart_prevention_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [CTRL_W-1:0] ctrl_q;
  logic [31:0]       dly_q;
  logic [31:0]       act_cnt;
  logic [3:0]        req_sh;
  logic [1:0]        cw;
  wire               req_now = pins_in.ch_a && pins_in.ch_b;
  wire               ctrl_wr = bus_req.wr && bus_req.addr == CTRL_OFS;
  // Pin levels are only judged once polarity has settled and test dips are off
  wire               ok = !ctrl_wr && cw == 2'h0 && ctrl_q[4:2] == 3'h0;
  wire               comp_on = pins_out.completion == ctrl_q[CTRL_POL_HIGH];
  ////////////////////////////////////////
  // Shadow of the settings, taken from the bus writes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= CTRL_RESET;
      dly_q  <= DELAY_CYCLES_DEF;
      cw     <= 2'h0;
    end else begin
      cw <= {cw[0], ctrl_wr};
      if (ctrl_wr) ctrl_q <= bus_req.wdata[CTRL_W-1:0];
      if (bus_req.wr && bus_req.addr == DELAY_OFS) dly_q <= bus_req.wdata;
    end
  end
  // Cycles spent active, and recent request history
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      act_cnt <= 32'h0;
      req_sh  <= 4'h0;
    end else begin
      act_cnt <= pins_out.activity ? act_cnt + 32'h1 : 32'h0;
      req_sh  <= {req_sh[2:0], req_now};
    end
  end
  ////////////////////////////////////////
  sequence s_idle;
    !pins_out.activity [*3];
  endsequence
  sequence s_no_press;
    !pins_in.ack_button [*6];
  endsequence
  a_rdata_idle: assert property (!bus_req.rd |=> rdata == 32'h0)
    else $error("read data not zero outside a read");
  a_both_chans: assert property (
    $rose(pins_out.activity) |-> $past(req_now, 2) || $past(req_now, 3) || $past(req_now, 4))
    else $error("activity rose without both channels");
  a_hold_active: assert property (
    $fell(pins_out.activity) |-> !$past(req_now, 2))
    else $error("activity dropped while request present");
  a_delay_met: assert property (
    ok && comp_on && !$past(comp_on) |-> act_cnt >= dly_q)
    else $error("completion before delay elapsed");
  a_comp_hold: assert property (
    ok && comp_on && (&req_sh) |=> comp_on)
    else $error("completion dropped while request held");
  a_idle_level: assert property (
    s_idle ##0 ok |-> pins_out.completion == !ctrl_q[CTRL_POL_HIGH])
    else $error("idle indication level wrong");
  a_warn_raise: assert property (
    $rose(pins_out.activity) |-> ##[0:2] irq)
    else $error("no interrupt on activation");
  a_auto_ack: assert property (
    !ctrl_q[CTRL_ACK_MAN] && $fell(req_now) |-> ##[1:8] !pins_out.activity)
    else $error("automatic acknowledge missing");
  a_manual_ack: assert property (
    s_no_press ##0 (ctrl_q[CTRL_ACK_MAN] && pins_out.activity) |=> pins_out.activity)
    else $error("activity dropped without button");
endmodule
bind start_prevention_indicator start_prevention_checker chk (.clk(clk), .rstn(rstn),
  .bus_req(bus_req), .rdata(rdata), .pins_in(pins_in), .pins_out(pins_out), .irq(irq));

// ### switch_wiring.sv
`timescale 1ns/1ps
module switch_wiring (
  input  wire logic clk,
  input  wire logic open_a,
  input  wire logic open_b,
  input  wire logic press,
  input  wire logic lamp,
  output logic      ch_a,
  output logic      ch_b,
  output logic      ack_button,
  output logic      out_readback
);
  // Both contact sets and the button start released
  initial begin
    ch_a = 1'b0;
    ch_b = 1'b0;
    ack_button = 1'b0;
  end
  // Contacts move just after an edge; each set has its own wire
  always @(posedge clk) begin
    ch_a       <= open_a;
    ch_b       <= open_b;
    ack_button <= press;
  end
  // Readback is the lamp wire itself, dips included
  assign out_readback = lamp;
endmodule

// ### start_prevention_indicator_bench.sv
`timescale 1ns/1ps
module start_prevention_indicator_bench;
  import restart_prevention_pkg::*;
  logic          clk = 1'b0;
  logic          rstn = 1'b0;
  reg_req_t      bus_req = '0;
  logic [31:0]   rdata;
  wire safe_in_t pins_in;
  safe_out_t     pins_out;
  logic          irq;
  logic          open_a = 1'b0;
  logic          open_b = 1'b0;
  logic          press = 1'b0;
  logic          rd_q;
  logic [31:0]   exp_q[$];
  logic [31:0]   dly;
  int            mismatches = 0;
  int            compares = 0;
  int            cycles = 0;
  int            n;
  ////////////////////////////////////////
  // Clock at 40 ns period
  always #20 clk = ~clk;
  start_prevention_indicator dut (.clk(clk), .rstn(rstn), .bus_req(bus_req),
    .rdata(rdata), .pins_in(pins_in), .pins_out(pins_out), .irq(irq));
  switch_wiring sw (.clk(clk), .open_a(open_a), .open_b(open_b), .press(press),
    .lamp(pins_out.completion), .ch_a(pins_in.ch_a), .ch_b(pins_in.ch_b),
    .ack_button(pins_in.ack_button), .out_readback(pins_in.out_readback));
  ////////////////////////////////////////
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: pin %b, expected %b", $time, got, exp);
    end
  endtask
  // One bus cycle; the strobe drops at the next edge
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    acc(1'b0, a, 32'h0);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic req(input logic a, input logic b);
    @(posedge clk);
    open_a <= a;
    open_b <= b;
  endtask
  task automatic push();
    @(posedge clk);
    press <= 1'b1;
    @(posedge clk);
    press <= 1'b0;
  endtask
  // Bounded wait on an output; n holds the cycles it took
  task automatic wait_out(input bit comp, input logic v, input int lim);
    n = 0;
    #1;
    while ((comp ? pins_out.completion : pins_out.activity) !== v && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  ////////////////////////////////////////
  // Read data stands one cycle after the strobe; match notes in order
  always @(posedge clk) begin
    rd_q = bus_req.rd;
    #1;
    if (rd_q) cmp_word(rdata, exp_q.pop_front());
  end
  // Cut a hang short far beyond the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      $display("wrong value at %0t: run hung", $time);
      give_verdict();
    end
  end
  ////////////////////////////////////////
  initial begin
    void'($urandom(4));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd(CTRL_OFS, 32'h3D);
    rd(DELAY_OFS, DELAY_CYCLES_DEF);
    rd(MASK_OFS, 32'h3);
    acc(1'b1, 4'hF, $urandom);
    rd(4'hF, 32'h0);
    dly = 32'd8 + ($urandom % 16);
    // Automatic mode, no test pulses, active high, short delay
    acc(1'b1, CTRL_OFS, 32'h21);
    acc(1'b1, DELAY_OFS, dly);
    rd(DELAY_OFS, dly);
    req(1'b1, 1'b0);
    cyc(12);
    cmp_bit(pins_out.activity, 1'b0);
    req(1'b0, 1'b1);
    cyc(12);
    cmp_bit(pins_out.activity, 1'b0);
    req(1'b1, 1'b1);
    wait_out(0, 1'b1, 8);
    cmp_bit(pins_out.activity, 1'b1);
    wait_out(1, 1'b1, 60);
    cmp_bit(pins_out.completion, 1'b1);
    cmp_bit(n >= dly, 1'b1);
    cmp_bit(irq, 1'b1);
    cyc(20);
    cmp_bit(pins_out.completion, 1'b1);
    rd(STATUS_OFS, 32'h3);
    rd(EVENT_OFS, 32'h3);
    acc(1'b1, EVENT_OFS, 32'h3);
    cyc(3);
    cmp_bit(irq, 1'b0);
    req(1'b0, 1'b0);
    wait_out(0, 1'b0, 10);
    cmp_bit(pins_out.activity, 1'b0);
    cyc(3);
    cmp_bit(pins_out.completion, 1'b0);
    // Early withdrawal must leave no completion; the next request counts afresh
    req(1'b1, 1'b1);
    cyc(dly / 2);
    req(1'b0, 1'b0);
    repeat (30) begin
      cyc(1);
      cmp_bit(pins_out.completion, 1'b0);
    end
    req(1'b1, 1'b1);
    wait_out(0, 1'b1, 8);
    wait_out(1, 1'b1, 60);
    cmp_bit(n >= dly, 1'b1);
    req(1'b0, 1'b0);
    wait_out(0, 1'b0, 10);
    // Manual acknowledge: button refused while the request stands
    acc(1'b1, CTRL_OFS, 32'h23);
    req(1'b1, 1'b1);
    wait_out(0, 1'b1, 8);
    push();
    cyc(10);
    cmp_bit(pins_out.activity, 1'b1);
    req(1'b0, 1'b0);
    cyc(12);
    cmp_bit(pins_out.activity, 1'b1);
    push();
    wait_out(0, 1'b0, 10);
    cmp_bit(pins_out.activity, 1'b0);
    // Inverted indication, and forced events behind a closed mask
    acc(1'b1, CTRL_OFS, 32'h01);
    acc(1'b1, MASK_OFS, 32'h0);
    acc(1'b1, EVENT_OFS, 32'h3F);
    rd(MASK_OFS, 32'h3);
    cyc(4);
    cmp_bit(pins_out.completion, 1'b1);
    cmp_bit(irq, 1'b0);
    req(1'b1, 1'b1);
    wait_out(1, 1'b0, 60);
    cmp_bit(pins_out.completion, 1'b0);
    cmp_bit(irq, 1'b1);
    req(1'b0, 1'b0);
    wait_out(0, 1'b0, 10);
    // Output test dips reach the lamp wire and read back, so no wiring fault shows
    acc(1'b1, CTRL_OFS, 32'h31);
    req(1'b1, 1'b1);
    wait_out(1, 1'b1, 60);
    wait_out(1, 1'b0, 260);
    cmp_bit(pins_out.completion, 1'b0);
    cmp_bit(pins_out.activity, 1'b1);
    rd(STATUS_OFS, 32'h3);
    req(1'b0, 1'b0);
    wait_out(0, 1'b0, 10);
    give_verdict();
  end
endmodule
